// ### src/ppi_pkg.sv
package ppi_pkg;
   // Register byte offsets
   localparam logic [7:0] OFS_P_DATA = 8'h18;
   localparam logic [7:0] OFS_P_DIR = 8'h1a;
   localparam logic [7:0] OFS_P_PWMSEL = 8'h1b;
   localparam logic [7:0] OFS_P_PULL_EN = 8'h1c;
   localparam logic [7:0] OFS_P_POL = 8'h1d;
   localparam logic [7:0] OFS_P_IRQ_EN = 8'h1e;
   localparam logic [7:0] OFS_P_IRQ_FLAG = 8'h1f;
   localparam logic [7:0] OFS_P_PIN_IN = 8'h19;
   localparam logic [7:0] OFS_AD_PULL_EN = 8'h34;
   localparam logic [7:0] OFS_AD_POL = 8'h35;
   localparam logic [7:0] OFS_AD_PIN_IN = 8'h36;
   // Reset values
   localparam logic [7:0] RST_ZERO = 8'h00;
   // Filter timing
   localparam int CLK_MHZ = 125;
   localparam int FILT_RUN_CLKS = 4;
   localparam real FILT_STOP_US = 10.0;
   localparam int FILT_STOP_CLKS = $rtoi(FILT_STOP_US * CLK_MHZ + 0.999);
   localparam int FILT_CNT_W = 11;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } ppi_bus_type;

   typedef struct packed {
      logic [7:0] out;
      logic [7:0] oe;
      logic [7:0] pull_up;
      logic [7:0] pull_down;
   } ppi_pad_type;
endpackage

// ### src/ppi_port.sv
// Function
// - Port P pull only for input pins
// - Pulls disabled after reset, both ports
// - Polarity clear: falling edge, pull-up
// - Polarity set: rising edge, pull-down
// - Converter channel enabled blocks AD pull
// - AD polarity selects up or down
// - Reset: port P high-impedance inputs
// - Port P pins selectable as PWM outputs
// - Eight pin requests share one interrupt
// - Per-pin interrupt enable and edge select
// - Edges detected for inputs and outputs
// - Request when flag and enable both set
// - Pending interrupt wakes from stop, wait
// - Keypad wake-up on all eight pins
// - Run filter: accept four clocks or more
// - Stop filter: accept ten microseconds or more
`timescale 1ns/100ps
`default_nettype none
module ppi_port #(
   parameter int FILT_STOP_CLKS = ppi_pkg::FILT_STOP_CLKS
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // Register port
   input wire ppi_pkg::ppi_bus_type bus_i,
   output logic [7:0] rdata_o,
   // Port P pads
   input wire logic [7:0] p_pin_i,
   input wire logic [7:0] pwm_i,
   output ppi_pkg::ppi_pad_type p_pad_o,
   // Port AD pads
   input wire logic [7:0] ad_pin_i,
   input wire logic [7:0] adc_chan_en_i,
   output logic [7:0] ad_pull_up_o,
   output logic [7:0] ad_pull_down_o,
   // Power state and interrupt
   input wire logic stop_mode_i,
   output logic irq_o,
   output logic wake_o
);
   ////////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      logic [7:0] p_data;
      logic [7:0] p_dir;
      logic [7:0] p_pwmsel;
      logic [7:0] p_pull_en;
      logic [7:0] p_pol;
      logic [7:0] p_irq_en;
      logic [7:0] p_flag;
      logic [7:0] ad_pull_en;
      logic [7:0] ad_pol;
      logic [7:0] p_s1;
      logic [7:0] p_s2;
      logic [7:0] p_s3;
      logic [7:0] a_s1;
      logic [7:0] a_s2;
      logic [7:0] a_s3;
      logic [7:0] p_filt;
      logic [7:0][ppi_pkg::FILT_CNT_W-1:0] cnt;
      logic [7:0] rdata;
      ppi_pkg::ppi_pad_type pad;
      logic [7:0] ad_pu;
      logic [7:0] ad_pd;
      logic irq;
      logic wake;
   } ppi_state_type;

   ppi_state_type state_reg;
   ppi_state_type state_next;

   ////////////////////////////////////////////////////////////////////////////
   logic [7:0] p_pin_out;
   logic [7:0] edge_hit;
   logic [ppi_pkg::FILT_CNT_W-1:0] thresh;

   always_comb begin
      state_next = state_reg;
      p_pin_out = 8'h00;
      edge_hit = 8'h00;
      thresh = stop_mode_i ? FILT_STOP_CLKS[ppi_pkg::FILT_CNT_W-1:0] :
         ppi_pkg::FILT_RUN_CLKS[ppi_pkg::FILT_CNT_W-1:0];

      // Pin synchronisers, change counts once stages two and three agree
      state_next.p_s1 = p_pin_i;
      state_next.p_s2 = state_reg.p_s1;
      state_next.p_s3 = state_reg.p_s2;
      state_next.a_s1 = ad_pin_i;
      state_next.a_s2 = state_reg.a_s1;
      state_next.a_s3 = state_reg.a_s2;

      // Glitch filter and edge detect per pin, any direction
      for (int i = 0; i < 8; i++) begin
         if (state_reg.p_s2[i] != state_reg.p_s3[i]) begin
            state_next.cnt[i] = '0;
         end else if (state_reg.p_s3[i] == state_reg.p_filt[i]) begin
            state_next.cnt[i] = '0;
         end else if (state_reg.cnt[i] + 11'h001 >= thresh - 11'h001) begin
            // Stable level reached threshold: accept the edge
            state_next.p_filt[i] = state_reg.p_s3[i];
            state_next.cnt[i] = '0;
            edge_hit[i] = (state_reg.p_s3[i] == state_reg.p_pol[i]);
         end else begin
            state_next.cnt[i] = state_reg.cnt[i] + 11'h001;
         end
      end

      // Register writes
      if (bus_i.wr) begin
         case (bus_i.addr)
            ppi_pkg::OFS_P_DATA: state_next.p_data = bus_i.wdata;
            ppi_pkg::OFS_P_DIR: state_next.p_dir = bus_i.wdata;
            ppi_pkg::OFS_P_PWMSEL: state_next.p_pwmsel = bus_i.wdata;
            ppi_pkg::OFS_P_PULL_EN: state_next.p_pull_en = bus_i.wdata;
            ppi_pkg::OFS_P_POL: state_next.p_pol = bus_i.wdata;
            ppi_pkg::OFS_P_IRQ_EN: state_next.p_irq_en = bus_i.wdata;
            ppi_pkg::OFS_P_IRQ_FLAG: state_next.p_flag = state_reg.p_flag & ~bus_i.wdata;
            ppi_pkg::OFS_AD_PULL_EN: state_next.ad_pull_en = bus_i.wdata;
            ppi_pkg::OFS_AD_POL: state_next.ad_pol = bus_i.wdata;
            default: state_next.p_data = state_reg.p_data;
         endcase
      end
      // Set wins over a same-cycle clear
      state_next.p_flag = state_next.p_flag | edge_hit;

      // Read data, valid the cycle after the strobe
      state_next.rdata = 8'h00;
      if (bus_i.rd) begin
         case (bus_i.addr)
            ppi_pkg::OFS_P_DATA: state_next.rdata = state_reg.p_data;
            ppi_pkg::OFS_P_PIN_IN: state_next.rdata = state_reg.p_s3;
            ppi_pkg::OFS_P_DIR: state_next.rdata = state_reg.p_dir;
            ppi_pkg::OFS_P_PWMSEL: state_next.rdata = state_reg.p_pwmsel;
            ppi_pkg::OFS_P_PULL_EN: state_next.rdata = state_reg.p_pull_en;
            ppi_pkg::OFS_P_POL: state_next.rdata = state_reg.p_pol;
            ppi_pkg::OFS_P_IRQ_EN: state_next.rdata = state_reg.p_irq_en;
            ppi_pkg::OFS_P_IRQ_FLAG: state_next.rdata = state_reg.p_flag;
            ppi_pkg::OFS_AD_PULL_EN: state_next.rdata = state_reg.ad_pull_en;
            ppi_pkg::OFS_AD_POL: state_next.rdata = state_reg.ad_pol;
            ppi_pkg::OFS_AD_PIN_IN: state_next.rdata = state_reg.a_s3;
            default: state_next.rdata = 8'h00;
         endcase
      end

      // Pad drive
      for (int i = 0; i < 8; i++) begin
         p_pin_out[i] = state_reg.p_pwmsel[i] ? pwm_i[i] : state_reg.p_data[i];
      end
      state_next.pad.out = p_pin_out;
      state_next.pad.oe = state_reg.p_dir | state_reg.p_pwmsel;
      state_next.pad.pull_up = state_reg.p_pull_en & ~state_next.pad.oe
         & ~state_reg.p_pol;
      state_next.pad.pull_down = state_reg.p_pull_en & ~state_next.pad.oe
         & state_reg.p_pol;
      state_next.ad_pu = state_reg.ad_pull_en & ~adc_chan_en_i & ~state_reg.ad_pol;
      state_next.ad_pd = state_reg.ad_pull_en & ~adc_chan_en_i & state_reg.ad_pol;

      state_next.irq = |(state_next.p_flag & state_next.p_irq_en);
      state_next.wake = state_next.irq;
   end

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign rdata_o = state_reg.rdata;
   assign p_pad_o = state_reg.pad;
   assign ad_pull_up_o = state_reg.ad_pu;
   assign ad_pull_down_o = state_reg.ad_pd;
   assign irq_o = state_reg.irq;
   assign wake_o = state_reg.wake;
endmodule
`default_nettype wire

// ### tb/ppi_pins.sv
`timescale 1ns/100ps
`default_nettype none
module ppi_pins (
   input wire logic clk_i,
   input wire ppi_pkg::ppi_pad_type pad_i,
   input wire logic [7:0] ext_i,
   input wire logic [7:0] ext_en_i,
   output logic [7:0] pin_o
);
   // Undriven, unpulled pins wander
   logic [7:0] drift_reg;
   initial drift_reg = 8'h55;
   always @(posedge clk_i) drift_reg <= ~drift_reg;
   assign pin_o = (pad_i.oe & pad_i.out) | (~pad_i.oe & ext_en_i & ext_i)
      | (~pad_i.oe & ~ext_en_i & (pad_i.pull_up | (~pad_i.pull_down & drift_reg)));
endmodule
`default_nettype wire

// ### tb/ppi_port_checker.sv
`timescale 1ns/100ps
`default_nettype none
module ppi_port_checker #(
   parameter int FILT_STOP_CLKS = 8
) (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire ppi_pkg::ppi_bus_type bus_i,
   input wire logic [7:0] rdata_o,
   input wire ppi_pkg::ppi_pad_type p_pad_o,
   input wire logic [7:0] adc_chan_en_i,
   input wire logic [7:0] ad_pull_up_o,
   input wire logic [7:0] ad_pull_down_o,
   input wire logic irq_o,
   input wire logic wake_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!resetn_i);
   a_wake_irq: assert property (wake_o == irq_o) else $error("wake");
   a_ad_block: assert property (($past(adc_chan_en_i) & $past(adc_chan_en_i, 2)
      & (ad_pull_up_o | ad_pull_down_o)) == 8'h00) else $error("ad pull");
   a_ad_excl: assert property ((ad_pull_up_o & ad_pull_down_o) == 8'h00) else $error("ad");
   a_p_excl: assert property ((p_pad_o.pull_up & p_pad_o.pull_down) == 8'h00) else $error("p");
   a_out_nopull: assert property (
      (p_pad_o.oe & (p_pad_o.pull_up | p_pad_o.pull_down)) == 8'h00) else $error("out pull");
   a_pull_clear: assert property (bus_i.wr && bus_i.addr == ppi_pkg::OFS_P_PULL_EN
      && bus_i.wdata == 8'h00 |-> ##2 (p_pad_o.pull_up | p_pad_o.pull_down) == 8'h00)
      else $error("pull");
   a_reset_hiz: assert property ($rose(resetn_i) |-> p_pad_o.oe == 8'h00) else $error("hiz");
   a_irq_mask: assert property (bus_i.wr && bus_i.addr == ppi_pkg::OFS_P_IRQ_EN
      && bus_i.wdata == 8'h00 |-> ##2 !irq_o) else $error("mask");
   a_pwm_drive: assert property (bus_i.wr && bus_i.addr == ppi_pkg::OFS_P_PWMSEL
      && bus_i.wdata == 8'hff |-> ##2 p_pad_o.oe == 8'hff) else $error("pwm");
   c_irq: cover property ($rose(irq_o));
   c_ad_up: cover property (|ad_pull_up_o);
   c_pwm: cover property (p_pad_o.oe == 8'hff);
endmodule
`default_nettype wire

// ### tb/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
   logic clk_i = 0, resetn_i = 0, stop = 0, irq, wake, rd_d = 0;
   logic [7:0] rdata, pins, up, dn, pwm = 0, adp = 0, adc = 0, ext = 8'hff, ext_en = 0;
   logic [31:0] seed = 32'h08871e99;
   logic [7:0] exp_q[$];
   int error_cnt = 0, checks_done = 0;
   ppi_pkg::ppi_bus_type bus = '0;
   ppi_pkg::ppi_pad_type pad;
   always #4 clk_i = ~clk_i;
   ppi_port #(.FILT_STOP_CLKS(8)) dut_u (.clk_i(clk_i), .resetn_i(resetn_i), .bus_i(bus),
      .rdata_o(rdata), .p_pin_i(pins), .pwm_i(pwm), .p_pad_o(pad), .ad_pin_i(adp),
      .adc_chan_en_i(adc), .ad_pull_up_o(up), .ad_pull_down_o(dn), .stop_mode_i(stop),
      .irq_o(irq), .wake_o(wake));
   ppi_pins pins_u (.clk_i(clk_i), .pad_i(pad), .ext_i(ext), .ext_en_i(ext_en), .pin_o(pins));
   ////////////////////////////////////////
   task automatic check(input logic [7:0] seen, input logic [7:0] want);
      checks_done++;
      if (seen !== want) begin
         error_cnt++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, want);
      end
   endtask
   function automatic logic [31:0] xorshift(input logic [31:0] s);
      logic [31:0] v;
      v = s ^ (s << 13);
      v = v ^ (v >> 17);
      v = v ^ (v << 5);
      return v;
   endfunction
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      bus <= '{a, d, 1'b1, 1'b0};
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk_i);
      bus <= '{a, 8'h00, 1'b0, 1'b1};
      exp_q.push_back(e);
   endtask
   task automatic idle(input int n);
      @(posedge clk_i);
      bus <= '0;
      repeat (n) @(posedge clk_i);
   endtask
   task automatic complete_run;
      if (error_cnt == 0 && checks_done > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   always @(posedge clk_i) rd_d <= bus.rd;
   always @(negedge clk_i) if (rd_d) check(rdata, exp_q.pop_front());
   initial begin
      #20000;
      error_cnt++;
      complete_run;
   end
   initial begin
      logic [7:0] r;
      repeat (4) @(posedge clk_i);
      resetn_i <= 1;
      rd(ppi_pkg::OFS_P_PULL_EN, 8'h00);
      rd(ppi_pkg::OFS_AD_PULL_EN, 8'h00);
      rd(8'h00, 8'h00);
      seed = xorshift(seed);
      r = seed[7:0];
      wr(ppi_pkg::OFS_P_POL, r);
      wr(ppi_pkg::OFS_P_PULL_EN, 8'hff);
      idle(8);
      rd(ppi_pkg::OFS_P_PIN_IN, ~r);
      wr(ppi_pkg::OFS_P_DIR, 8'hff);
      wr(ppi_pkg::OFS_P_PWMSEL, 8'hff);
      pwm <= r;
      adc <= r;
      adp <= r;
      wr(ppi_pkg::OFS_AD_PULL_EN, 8'hff);
      wr(ppi_pkg::OFS_AD_POL, 8'h0f);
      idle(4);
      @(negedge clk_i);
      check(pad.out, r);
      check(up, ~r & 8'hf0);
      check(dn, ~r & 8'h0f);
      rd(ppi_pkg::OFS_AD_PIN_IN, r);
      wr(ppi_pkg::OFS_P_PWMSEL, 8'h00);
      wr(ppi_pkg::OFS_P_DIR, 8'h00);
      wr(ppi_pkg::OFS_P_PULL_EN, 8'h00);
      for (int p = 0; p < 2; p++) begin
         wr(ppi_pkg::OFS_P_POL, {8{p[0]}});
         ext <= {8{!p[0]}};
         ext_en <= 8'hff;
         wr(ppi_pkg::OFS_P_IRQ_EN, 8'h01);
         idle(10);
         wr(ppi_pkg::OFS_P_IRQ_FLAG, 8'hff);
         ext[0] <= p[0];
         idle(2);
         ext[0] <= !p[0];
         idle(12);
         @(negedge clk_i);
         check({7'h00, irq}, 8'h00);
         @(posedge clk_i);
         ext[0] <= p[0];
         idle(12);
         @(negedge clk_i);
         check({7'h00, irq}, 8'h01);
         wr(ppi_pkg::OFS_P_IRQ_FLAG, 8'h00);
         rd(ppi_pkg::OFS_P_IRQ_FLAG, 8'h01);
         wr(ppi_pkg::OFS_P_IRQ_EN, 8'h00);
         idle(2);
         @(negedge clk_i);
         check({7'h00, irq}, 8'h00);
         wr(ppi_pkg::OFS_P_IRQ_FLAG, 8'h01);
         ext[0] <= !p[0];
         idle(12);
         rd(ppi_pkg::OFS_P_IRQ_FLAG, 8'h00);
      end
      // Stop-mode filter: short pulse dropped, long pulse taken
      stop <= 1'b1;
      wr(ppi_pkg::OFS_P_IRQ_FLAG, 8'hff);
      ext[0] <= 1'b1;
      idle(5);
      ext[0] <= 1'b0;
      idle(14);
      rd(ppi_pkg::OFS_P_IRQ_FLAG, 8'h00);
      ext[0] <= 1'b1;
      idle(14);
      rd(ppi_pkg::OFS_P_IRQ_FLAG, 8'h01);
      wr(ppi_pkg::OFS_P_IRQ_EN, 8'h01);
      idle(2);
      @(negedge clk_i);
      check({7'h00, wake}, 8'h01);
      idle(3);
      complete_run;
   end
endmodule
bind ppi_port ppi_port_checker #(.FILT_STOP_CLKS(FILT_STOP_CLKS)) chk_u (.clk_i(clk_i),
   .resetn_i(resetn_i), .bus_i(bus_i), .rdata_o(rdata_o), .p_pad_o(p_pad_o),
   .adc_chan_en_i(adc_chan_en_i), .ad_pull_up_o(ad_pull_up_o),
   .ad_pull_down_o(ad_pull_down_o), .irq_o(irq_o), .wake_o(wake_o));
`default_nettype wire
